// file: gain_cal_pkg.sv
// Package: register map, field layout and reset values for gain calibration
package gain_cal_pkg;
  // Printed offsets are word indices; byte address is four times the index
  localparam logic [7:0]  GAIN_UPPER_INDEX  = 8'h0C;
  localparam logic [7:0]  GAIN_LOWER_INDEX  = 8'h0D;
  localparam logic [11:0] GAIN_UPPER_ADDR   = {2'h0, GAIN_UPPER_INDEX, 2'h0};
  localparam logic [11:0] GAIN_LOWER_ADDR   = {2'h0, GAIN_LOWER_INDEX, 2'h0};
  localparam logic [15:0] GAIN_UPPER_RESET  = 16'h8000;
  localparam logic [7:0]  GAIN_LOW_RESET    = 8'h00;
  localparam int          LOW_FIELD_LSB     = 8;
  localparam int          COEFF_WIDTH       = 24;
  localparam int          REG_WIDTH         = 16;
endpackage

// file: gain_coeff_store.sv
// Storage flops for the 24-bit gain coefficient
`timescale 1ns/1ps
`default_nettype none
module gain_coeff_store
  import gain_cal_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_high,
  input  wire logic        wr_low,
  input  wire logic [15:0] wdata,
  output logic      [23:0] coeff
);
  logic [15:0] high_bits;
  logic [7:0]  low_bits;

  // Upper sixteen coefficient bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      high_bits <= GAIN_UPPER_RESET;
    else if (wr_high)
      high_bits <= wdata;
  end

  // Low byte comes from the upper byte of the written word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_bits <= GAIN_LOW_RESET;
    else if (wr_low)
      low_bits <= wdata[15:8];
  end

  // Separate halves so each flop group has a single writer
  assign coeff = {high_bits, low_bits};
endmodule // gain_coeff_store
`default_nettype wire

// file: adc_channel_gain_calibration.sv
// APB register pair holding the channel 0 gain coefficient
//
// Operation
// - Upper register at index 0Ch holds coefficient bits 23:8 read/write.
// - Upper register resets to 8000h so the gain starts at mid-scale.
// - Lower register at index 0Dh holds bits 7:0 in 15:8, reset 0000h.
// - The 24-bit coefficient is an unsigned fraction from 0 to under 2.
// - Bits 7:0 of the lower register read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module adc_channel_gain_calibration
  import gain_cal_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [23:0] gain_coeff,
  output logic      [1:0]  gain_integer,
  output logic      [23:0] gain_fraction
);
  logic        access;
  logic        setup_read;
  logic        any_write;
  logic        hit_high;
  logic        hit_low;
  logic        hit_none;
  logic        wr_high;
  logic        wr_low;
  logic [15:0] high_word;
  logic [15:0] low_word;
  logic [15:0] store_word;
  logic [15:0] read_word;
  logic [23:0] coeff;

  // Address match, shared by the write decode and the read mux
  function automatic logic addr_hits(input logic [11:0] addr,
                                     input logic [11:0] slot);
    return addr == slot;
  endfunction

  // Lane merge: strobed byte from the bus, otherwise the held byte
  function automatic logic [7:0] lane_pick(input logic       strobe,
                                           input logic [7:0] fresh,
                                           input logic [7:0] held);
    return strobe ? fresh : held;
  endfunction

  // Read image of one register slot; unmapped slots read zero
  function automatic logic [15:0] read_image(input logic [11:0] addr,
                                             input logic [23:0] value);
    logic [15:0] image;
    image = 16'h0000;
    if (addr_hits(addr, GAIN_UPPER_ADDR))
      image = value[23:8];
    else if (addr_hits(addr, GAIN_LOWER_ADDR))
      image = {value[7:0], 8'h00};
    return image;
  endfunction

  // Bus phases; zero-wait slave, answers in the access cycle
  assign access     = psel && penable;
  assign setup_read = psel && !penable && !pwrite;
  assign any_write  = access && pwrite;

  // Slot decode
  assign hit_high = addr_hits(paddr, GAIN_UPPER_ADDR);
  assign hit_low  = addr_hits(paddr, GAIN_LOWER_ADDR);
  assign hit_none = !(hit_high || hit_low);

  // Handshake outputs stay combinational; no wait states needed
  assign pready  = 1'b1;
  assign pslverr = access && hit_none;

  // Write enables; lower write needs the lane that carries bits 7:0
  assign wr_high = any_write && hit_high;
  assign wr_low  = any_write && hit_low && pstrb[1];

  // Partial upper writes keep the lane that was not strobed
  assign high_word = {lane_pick(pstrb[1], pwdata[15:8], coeff[23:16]),
                      lane_pick(pstrb[0], pwdata[7:0], coeff[15:8])};

  // Reserved low lane is dropped here, so writes never reach it
  assign low_word = {pwdata[15:8], 8'h00};

  // One word bus into the store; its enables pick the half
  assign store_word = hit_high ? high_word : low_word;

  // Coefficient flops live in their own module
  gain_coeff_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_high (wr_high),
    .wr_low  (wr_low),
    .wdata   (store_word),
    .coeff   (coeff)
  );

  // Read image picked in the setup cycle
  assign read_word = read_image(paddr, coeff);

  // Read data registered at setup so it stands through the access
  // cycle; costs nothing since pready never stalls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_read)
      prdata <= {16'h0000, read_word};
  end

  // Unsigned 1.23 fixed point: bit 23 weighs one
  assign gain_coeff    = coeff;
  assign gain_integer  = {1'b0, coeff[23]};
  assign gain_fraction = {1'b0, coeff[22:0]};

  // Read of the upper slot returns coefficient bits 23:8
  sequence s_upper_read_setup;
    setup_read && hit_high;
  endsequence

  sequence s_upper_read_data;
    prdata == {16'h0000, $past(coeff[23:8])};
  endsequence

  property p_read_upper;
    @(posedge pclk) disable iff (!presetn)
    s_upper_read_setup |=> s_upper_read_data;
  endproperty
  a_read_upper: assert property (p_read_upper)
    else $error("upper read data wrong");

  // Read of the lower slot returns bits 7:0 in the upper byte
  sequence s_lower_read_setup;
    setup_read && hit_low;
  endsequence

  sequence s_lower_read_data;
    prdata == {16'h0000, $past(coeff[7:0]), 8'h00};
  endsequence

  property p_read_lower;
    @(posedge pclk) disable iff (!presetn)
    s_lower_read_setup |=> s_lower_read_data;
  endproperty
  a_read_lower: assert property (p_read_lower)
    else $error("lower read data wrong");

  // Writes to unmapped slots leave the coefficient alone
  property p_unmapped_quiet;
    @(posedge pclk) disable iff (!presetn)
    (any_write && hit_none) |=> $stable(coeff);
  endproperty
  a_unmapped_quiet: assert property (p_unmapped_quiet)
    else $error("unmapped write changed gain");

  // Unmapped access is flagged while the access cycle stands
  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
    (access && hit_none) |-> pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not flagged");

  // Lower write without the data lane changes nothing
  property p_low_no_lane;
    @(posedge pclk) disable iff (!presetn)
    (any_write && hit_low && !pstrb[1]) |=> $stable(coeff);
  endproperty
  a_low_no_lane: assert property (p_low_no_lane)
    else $error("lower write without lane landed");

  // Partial upper write: low lane only, high lane kept
  sequence s_high_low_lane;
    wr_high && pstrb[1:0] == 2'h1;
  endsequence

  sequence s_high_lane_kept;
    coeff[23:16] == $past(coeff[23:16])
      && coeff[15:8] == $past(pwdata[7:0]);
  endsequence

  property p_high_partial;
    @(posedge pclk) disable iff (!presetn)
    s_high_low_lane |=> s_high_lane_kept;
  endproperty
  a_high_partial: assert property (p_high_partial)
    else $error("partial upper write wrong");

  // Upper write leaves the low byte alone
  property p_high_no_touch_low;
    @(posedge pclk) disable iff (!presetn)
    wr_high |=> $stable(coeff[7:0]);
  endproperty
  a_high_no_touch_low: assert property (p_high_no_touch_low)
    else $error("upper write disturbed lower");

  // Reset values land on both halves
  property p_reset_mid;
    @(posedge pclk) $rose(presetn) |-> coeff == 24'h80_0000;
  endproperty
  a_reset_mid: assert property (p_reset_mid)
    else $error("gain not mid-scale after reset");

  property p_high_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_high && pstrb[1:0] == 2'h3) |=> coeff[23:8] == $past(pwdata[15:0]);
  endproperty
  a_high_write: assert property (p_high_write)
    else $error("upper gain write lost");

  property p_low_write;
    @(posedge pclk) disable iff (!presetn)
    wr_low |=> coeff[7:0] == $past(pwdata[15:8]);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("lower gain write lost");

  property p_low_reserved;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_low) |=> prdata[7:0] == 8'h00;
  endproperty
  a_low_reserved: assert property (p_low_reserved)
    else $error("reserved bits not zero");

  property p_low_no_touch_high;
    @(posedge pclk) disable iff (!presetn)
    wr_low |=> $stable(coeff[23:8]);
  endproperty
  a_low_no_touch_high: assert property (p_low_no_touch_high)
    else $error("lower write disturbed upper");

  property p_integer;
    @(posedge pclk) disable iff (!presetn)
    gain_integer == {1'b0, gain_coeff[23]};
  endproperty
  a_integer: assert property (p_integer)
    else $error("gain integer part wrong");
endmodule // adc_channel_gain_calibration
`default_nettype wire

// file: adc_channel_gain_calibration_test.sv
// Testbench for the channel 0 gain calibration register pair
`timescale 1ns/1ps
`default_nettype none
module adc_channel_gain_calibration_test
  import gain_cal_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic [23:0] gain_coeff, gain_fraction;
  logic [1:0]  gain_integer;
  int          errors, total_checks, cycles;
  adc_channel_gain_calibration i_adc_channel_gain_calibration (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gain_coeff(gain_coeff),
    .gain_integer(gain_integer), .gain_fraction(gain_fraction));
  // 250 MHz clock
  initial
  begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, g);
    total_checks++;
    if (g !== x)
    begin
      $display("[FAIL] %s exp %h got %h", n, x, g);
      errors++;
    end
  endtask
  // One APB transfer; waits for pready, bench timeout cuts a hang
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(negedge pclk); // let outputs launched at that edge settle
  endtask
  task automatic t_reset;
    apb(0, GAIN_UPPER_ADDR, 0); chk("upper", 32'h8000, r);
    apb(0, GAIN_LOWER_ADDR, 0); chk("lower", 32'h0, r);
    chk("coeff", 32'h800000, {8'h0, gain_coeff});
    chk("integer", 32'h1, {30'h0, gain_integer});
  endtask
  // Low byte written all ones must still read zero
  task automatic t_write;
    apb(1, GAIN_UPPER_ADDR, 32'h0000FFFF);
    apb(1, GAIN_LOWER_ADDR, 32'h000012FF);
    apb(0, GAIN_UPPER_ADDR, 0); chk("upper", 32'hFFFF, r);
    apb(0, GAIN_LOWER_ADDR, 0); chk("lower", 32'h1200, r);
    chk("coeff", 32'hFFFF12, {8'h0, gain_coeff});
    chk("frac", 32'h7FFF12, {8'h0, gain_fraction});
    apb(1, GAIN_UPPER_ADDR, 32'h0); apb(1, GAIN_LOWER_ADDR, 32'h0);
    chk("zero", 32'h0, {8'h0, gain_coeff});
  endtask
  // Unmapped slot just above both registers: error, no side effect
  task automatic t_unmapped;
    apb(1, 12'h038, 32'h0000ABCD); chk("err", 32'h1, {31'h0, e});
    apb(0, 12'h038, 0); chk("rd", 32'h0, r);
    chk("coeff", 32'h0, {8'h0, gain_coeff});
  endtask
  // Hang guard, far above the few dozen cycles needed
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      close_out;
    end
  end
  initial
  begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; pstrb = 4'hF;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_write;
    t_unmapped;
    close_out;
  end
endmodule // adc_channel_gain_calibration_test
`default_nettype wire
